/* design/fesr_host.sv */
// Host controller that drives a parallel flash through program, erase, poll and reset.
//
// Contract
// - Completion is detected either from the toggling status bit or from data polling.
// - The host holds reset low for at least 500 ns.
// - The host keeps reset high for at least 50 ns before the next read.
// - For temporary unprotect the host holds the high reset level 4 us before writes.
// - Protect write pulses are at least 100 ns wide.
// - Output enable is asserted at least 4 us before the protect write strobe.
`default_nettype none
module fesr_host #(
  parameter int unsigned POLL_TIMEOUT = fesr_pkg::POLL_TIMEOUT_DEF,
  parameter int unsigned RECOVERY_BUSY = fesr_pkg::RECOVERY_BUSY_CYC,
  parameter int unsigned UNPROT_SETUP = fesr_pkg::UNPROT_SETUP_CYC,
  parameter int unsigned PROT_OE = fesr_pkg::PROT_OE_CYC
) (
  input  wire logic                      sys_clk,
  input  wire logic                      rst,
  input  wire logic                      reqValid,
  input  wire logic [2:0]                reqOp,
  input  wire logic [1:0]                reqPollMode,
  input  wire logic [fesr_pkg::ADDR_W-1:0] reqAddr,
  input  wire logic [fesr_pkg::DATA_W-1:0] reqData,
  output logic                           reqReady,
  output logic                           doneValid,
  output logic                           doneFail,
  output logic [fesr_pkg::DATA_W-1:0]    doneData,
  output logic [fesr_pkg::ADDR_W-1:0]    flashAddr,
  output logic [fesr_pkg::DATA_W-1:0]    flashDqOut,
  output logic                           flashDqOe,
  input  wire logic [fesr_pkg::DATA_W-1:0] flashDqIn,
  output logic                           flashCeN,
  output logic                           flashOeN,
  output logic                           flashWeN,
  output logic                           flashResetN,
  output logic                           highVoltageIdLevel
);
  import fesr_pkg::*;

  // ****************************************************************
  // State and timer.
  // ****************************************************************
  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0000,
    ST_SEQ     = 4'b0001,
    ST_WLOW    = 4'b0010,
    ST_WHIGH   = 4'b0011,
    ST_RLOW    = 4'b0100,
    ST_RSAMP   = 4'b0101,
    ST_RSTLOW  = 4'b0110,
    ST_RSTHIGH = 4'b0111,
    ST_PROT_OE = 4'b1000,
    ST_PROT_WE = 4'b1001,
    ST_DONE    = 4'b1010
  } fesr_state_t;

  fesr_state_t      state_ff;
  fesr_timer_if     tmrBus ();
  logic             tmrLoad_ff;
  logic [CNT_W-1:0] tmrCount_ff;
  logic [7:0]       dqSync1_ff;
  logic [7:0]       dqSync2_ff;
  logic [2:0]       op_ff;
  logic [1:0]       pollMode_ff;
  logic [2:0]       seqIdx_ff;
  logic             polling_ff;
  logic             havePrev_ff;
  logic [7:0]       prevRead_ff;
  logic [CNT_W-1:0] pollCnt_ff;
  logic             algoRunning_ff;
  logic [ADDR_W-1:0] opAddr_ff;
  logic [7:0]       opData_ff;
  logic [ADDR_W-1:0] seqAddr;
  logic [7:0]       seqData;
  logic [2:0]       seqLen;
  logic             pollDone;

  assign tmrBus.load  = tmrLoad_ff;
  assign tmrBus.count = tmrCount_ff;

  fesr_timer u_timer (
    .sys_clk (sys_clk),
    .rst     (rst),
    .tmr     (tmrBus)
  );

  // ****************************************************************
  // Data pin synchroniser.
  // ****************************************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      dqSync1_ff <= 8'h00;
      dqSync2_ff <= 8'h00;
    end else begin
      dqSync1_ff <= flashDqIn;
      dqSync2_ff <= dqSync1_ff;
    end
  end

  // ****************************************************************
  // Command sequence table.
  // ****************************************************************
  always_comb begin
    seqAddr = 20'h00555;
    seqData = 8'haa;
    seqLen  = 3'h4;
    if (op_ff != OP_PROGRAM) begin
      seqLen = 3'h6;
    end
    case (seqIdx_ff)
      3'h0: begin
        seqAddr = 20'h00555;
        seqData = 8'haa;
      end
      3'h1: begin
        seqAddr = 20'h002aa;
        seqData = 8'h55;
      end
      3'h2: begin
        seqAddr = 20'h00555;
        seqData = (op_ff == OP_PROGRAM) ? 8'ha0 : 8'h80;
      end
      3'h3: begin
        seqAddr = (op_ff == OP_PROGRAM) ? opAddr_ff : 20'h00555;
        seqData = (op_ff == OP_PROGRAM) ? opData_ff : 8'haa;
      end
      3'h4: begin
        seqAddr = 20'h002aa;
        seqData = 8'h55;
      end
      default: begin
        seqAddr = (op_ff == OP_SECTOR_ERASE) ?
          {opAddr_ff[SECTOR_HI:SECTOR_LO], 13'h0000} : 20'h00555;
        seqData = (op_ff == OP_SECTOR_ERASE) ? SECTOR_ERASE_DATA : CHIP_ERASE_DATA;
      end
    endcase
  end

  // Erase expects 1 and program expects the written bit; toggling stops when done.
  always_comb begin
    if (pollMode_ff == POLL_TOGGLE) begin
      pollDone = havePrev_ff &&
        (prevRead_ff[TOGGLE_STATUS_BIT] == dqSync2_ff[TOGGLE_STATUS_BIT]);
    end else if (op_ff == OP_PROGRAM) begin
      pollDone = dqSync2_ff[DATA_POLL_BIT] == opData_ff[DATA_POLL_BIT];
    end else begin
      pollDone = dqSync2_ff[DATA_POLL_BIT];
    end
  end

  // ****************************************************************
  // Main sequencer.
  // ****************************************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      op_ff <= OP_READ;
      pollMode_ff <= POLL_DATA;
      seqIdx_ff <= 3'h0;
      polling_ff <= 1'b0;
      havePrev_ff <= 1'b0;
      prevRead_ff <= 8'h00;
      pollCnt_ff <= '0;
      algoRunning_ff <= 1'b0;
      opAddr_ff <= '0;
      opData_ff <= 8'h00;
      tmrLoad_ff <= 1'b0;
      tmrCount_ff <= '0;
      reqReady <= 1'b0;
      doneValid <= 1'b0;
      doneFail <= 1'b0;
      doneData <= 8'h00;
      flashAddr <= '0;
      flashDqOut <= 8'h00;
      flashDqOe <= 1'b0;
      flashCeN <= 1'b1;
      flashOeN <= 1'b1;
      flashWeN <= 1'b1;
      flashResetN <= 1'b1;
      highVoltageIdLevel <= 1'b0;
    end else begin
      tmrLoad_ff <= 1'b0;
      doneValid <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          reqReady <= 1'b1;
          if (reqValid && reqReady) begin
            reqReady <= 1'b0;
            op_ff <= reqOp;
            pollMode_ff <= reqPollMode;
            opAddr_ff <= reqAddr;
            opData_ff <= reqData;
            seqIdx_ff <= 3'h0;
            havePrev_ff <= 1'b0;
            pollCnt_ff <= '0;
            doneFail <= 1'b0;
            tmrLoad_ff <= 1'b1;
            case (reqOp)
              OP_RESET: begin
                flashResetN <= 1'b0;
                tmrCount_ff <= CNT_W'(RESET_PULSE_CYC);
                state_ff <= ST_RSTLOW;
              end
              OP_READ: begin
                flashAddr <= reqAddr;
                flashCeN <= 1'b0;
                flashOeN <= 1'b0;
                tmrCount_ff <= CNT_W'(STROBE_CYC);
                state_ff <= ST_RLOW;
              end
              OP_PROTECT_PULSE: begin
                flashAddr <= reqAddr;
                flashCeN <= 1'b0;
                flashOeN <= 1'b0;
                tmrCount_ff <= CNT_W'(PROT_OE);
                state_ff <= ST_PROT_OE;
              end
              OP_UNPROTECT_ENTRY: begin
                highVoltageIdLevel <= 1'b1;
                tmrCount_ff <= CNT_W'(UNPROT_SETUP);
                state_ff <= ST_DONE;
              end
              default: begin
                state_ff <= ST_SEQ;
              end
            endcase
          end
        end
        ST_SEQ: begin
          flashAddr <= seqAddr;
          flashDqOut <= seqData;
          flashDqOe <= 1'b1;
          flashCeN <= 1'b0;
          flashWeN <= 1'b0;
          tmrLoad_ff <= 1'b1;
          tmrCount_ff <= CNT_W'(STROBE_CYC);
          state_ff <= ST_WLOW;
        end
        ST_WLOW: begin
          if (tmrBus.done && !tmrLoad_ff) begin
            flashWeN <= 1'b1;
            tmrLoad_ff <= 1'b1;
            tmrCount_ff <= CNT_W'(STROBE_CYC);
            state_ff <= ST_WHIGH;
          end
        end
        ST_WHIGH: begin
          if (tmrBus.done && !tmrLoad_ff) begin
            flashCeN <= 1'b1;
            flashDqOe <= 1'b0;
            if (seqIdx_ff == seqLen - 3'h1) begin
              algoRunning_ff <= 1'b1;
              polling_ff <= 1'b1;
              flashAddr <= opAddr_ff;
              flashCeN <= 1'b0;
              flashOeN <= 1'b0;
              tmrLoad_ff <= 1'b1;
              tmrCount_ff <= CNT_W'(STROBE_CYC);
              state_ff <= ST_RLOW;
            end else begin
              seqIdx_ff <= seqIdx_ff + 3'h1;
              state_ff <= ST_SEQ;
            end
          end
        end
        ST_RLOW: begin
          flashCeN <= 1'b0;
          flashOeN <= 1'b0;
          if (tmrBus.done && !tmrLoad_ff) begin
            state_ff <= ST_RSAMP;
          end
        end
        ST_RSAMP: begin
          flashCeN <= 1'b1;
          flashOeN <= 1'b1;
          doneData <= dqSync2_ff;
          prevRead_ff <= dqSync2_ff;
          havePrev_ff <= 1'b1;
          if (!polling_ff) begin
            doneValid <= 1'b1;
            state_ff <= ST_IDLE;
          end else if (pollDone) begin
            polling_ff <= 1'b0;
            algoRunning_ff <= 1'b0;
            doneValid <= 1'b1;
            state_ff <= ST_IDLE;
          end else if (pollCnt_ff == CNT_W'(POLL_TIMEOUT)) begin
            polling_ff <= 1'b0;
            doneFail <= 1'b1;
            doneValid <= 1'b1;
            state_ff <= ST_IDLE;
          end else begin
            pollCnt_ff <= pollCnt_ff + CNT_W'(1);
            tmrLoad_ff <= 1'b1;
            tmrCount_ff <= CNT_W'(STROBE_CYC);
            state_ff <= ST_RLOW;
          end
        end
        ST_RSTLOW: begin
          if (tmrBus.done && !tmrLoad_ff) begin
            flashResetN <= 1'b1;
            tmrLoad_ff <= 1'b1;
            if (algoRunning_ff) begin
              tmrCount_ff <= CNT_W'(RECOVERY_BUSY);
            end else begin
              tmrCount_ff <= CNT_W'(RECOVERY_IDLE_CYC + RESET_HIGH_CYC);
            end
            algoRunning_ff <= 1'b0;
            state_ff <= ST_RSTHIGH;
          end
        end
        ST_PROT_OE: begin
          if (tmrBus.done && !tmrLoad_ff) begin
            flashWeN <= 1'b0;
            tmrLoad_ff <= 1'b1;
            tmrCount_ff <= CNT_W'(PROT_PULSE_CYC);
            state_ff <= ST_PROT_WE;
          end
        end
        ST_PROT_WE: begin
          if (tmrBus.done && !tmrLoad_ff) begin
            flashWeN <= 1'b1;
            flashOeN <= 1'b1;
            flashCeN <= 1'b1;
            doneValid <= 1'b1;
            state_ff <= ST_IDLE;
          end
        end
        ST_RSTHIGH, ST_DONE: begin
          if (tmrBus.done && !tmrLoad_ff) begin
            doneValid <= 1'b1;
            state_ff <= ST_IDLE;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  reset_pulse_width_a: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(flashResetN) |-> !flashResetN [*8])
    else $error("Reset pulse shorter than minimum.");

  protect_we_width_a: assert property (@(posedge sys_clk) disable iff (rst)
    ($fell(flashWeN) && state_ff == ST_PROT_WE) |=> !flashWeN [*8])
    else $error("Protect write pulse too short.");

  protect_oe_setup_a: assert property (@(posedge sys_clk) disable iff (rst)
    ($fell(flashWeN) && state_ff == ST_PROT_WE) |-> !$past(flashOeN, 8))
    else $error("Output enable not set up before protect strobe.");

  reset_read_gap_a: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(flashResetN) |-> flashOeN [*5])
    else $error("Read started too soon after reset.");

  unprotect_setup_a: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(highVoltageIdLevel) |-> flashWeN [*8])
    else $error("Write strobe inside unprotect setup.");

  poll_complete_a: assert property (@(posedge sys_clk) disable iff (rst)
    (state_ff == ST_RSAMP && polling_ff && op_ff != OP_PROGRAM &&
     pollMode_ff == POLL_DATA && dqSync2_ff[DATA_POLL_BIT]) |=> doneValid && !doneFail)
    else $error("Erase completion not reported.");

  sector_address_a: assert property (@(posedge sys_clk) disable iff (rst)
    (!flashWeN && op_ff == OP_SECTOR_ERASE && seqIdx_ff == 3'h5) |->
      flashAddr[SECTOR_HI:SECTOR_LO] == opAddr_ff[SECTOR_HI:SECTOR_LO])
    else $error("Sector address not on upper lines.");
endmodule
`default_nettype wire

/* design/fesr_pkg.sv */
// Package with constants for the flash erase and status controller.
`default_nettype none
package fesr_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned RESET_PULSE_MIN_NS = 500;
  localparam int unsigned RESET_HIGH_BEFORE_READ_NS = 50;
  localparam int unsigned RESET_RECOVERY_BUSY_US = 20;
  localparam int unsigned RESET_RECOVERY_IDLE_NS = 500;
  localparam int unsigned UNPROTECT_RESET_SETUP_US = 4;
  localparam int unsigned PROT_WRITE_PULSE_NS = 100;
  localparam int unsigned PROT_OE_SETUP_US = 4;
  localparam int unsigned STROBE_NS = 50;
  localparam int unsigned RESET_PULSE_CYC = (RESET_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RESET_HIGH_CYC =
    (RESET_HIGH_BEFORE_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RECOVERY_BUSY_CYC = RESET_RECOVERY_BUSY_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned RECOVERY_IDLE_CYC = RESET_RECOVERY_IDLE_NS / CLK_PERIOD_NS;
  localparam int unsigned UNPROT_SETUP_CYC = UNPROTECT_RESET_SETUP_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned PROT_PULSE_CYC = (PROT_WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PROT_OE_CYC = PROT_OE_SETUP_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned POLL_TIMEOUT_DEF = 2000000;
  localparam int unsigned CNT_W = 24;
  localparam int unsigned ADDR_W = 20;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned SECTOR_LO = 13;
  localparam int unsigned SECTOR_HI = 19;
  localparam int unsigned DATA_POLL_BIT = 7;
  localparam int unsigned TOGGLE_STATUS_BIT = 6;
  localparam logic [7:0] SECTOR_ERASE_DATA = 8'h30;
  localparam logic [7:0] CHIP_ERASE_DATA = 8'h10;
  localparam logic [2:0] OP_PROGRAM = 3'h0;
  localparam logic [2:0] OP_CHIP_ERASE = 3'h1;
  localparam logic [2:0] OP_SECTOR_ERASE = 3'h2;
  localparam logic [2:0] OP_RESET = 3'h3;
  localparam logic [2:0] OP_READ = 3'h4;
  localparam logic [2:0] OP_PROTECT_PULSE = 3'h5;
  localparam logic [2:0] OP_UNPROTECT_ENTRY = 3'h6;
  localparam logic [1:0] POLL_DATA = 2'h0;
  localparam logic [1:0] POLL_TOGGLE = 2'h1;
endpackage
`default_nettype wire

/* design/fesr_timer.sv */
// Down counter that flags when a loaded delay has expired.
`default_nettype none
module fesr_timer (
  input  wire logic   sys_clk,
  input  wire logic   rst,
  fesr_timer_if.slave tmr
);
  import fesr_pkg::*;
  logic [CNT_W-1:0] remain_ff;
  logic             done_ff;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      remain_ff <= '0;
      done_ff   <= 1'b0;
    end else if (tmr.load) begin
      remain_ff <= tmr.count;
      done_ff   <= 1'b0;
    end else if (remain_ff > CNT_W'(1)) begin
      remain_ff <= remain_ff - CNT_W'(1);
    end else begin
      remain_ff <= '0;
      done_ff   <= 1'b1;
    end
  end
  assign tmr.done = done_ff;
endmodule
`default_nettype wire

/* design/fesr_timer_if.sv */
// Interface between the controller and its delay timer.
`default_nettype none
interface fesr_timer_if;
  import fesr_pkg::*;
  logic             load;
  logic [CNT_W-1:0] count;
  logic             done;
  modport master (output load, output count, input done);
  modport slave  (input load, input count, output done);
endinterface
`default_nettype wire

/* verification/fesr_flash_model.sv */
// Behavioural model of the parallel flash device driven by the host controller.
`default_nettype none
module fesr_flash_model #(
  parameter int unsigned PROG_CYC  = 30,
  parameter int unsigned ERASE_CYC = 60
) (
  input  wire logic                        clk,
  input  wire logic                        stuck,
  input  wire logic [fesr_pkg::ADDR_W-1:0] addr,
  input  wire logic [fesr_pkg::DATA_W-1:0] dqIn,
  input  wire logic                        ceN,
  input  wire logic                        oeN,
  input  wire logic                        weN,
  input  wire logic                        resetN,
  output logic [fesr_pkg::DATA_W-1:0]      dqOut,
  output logic                             busy,
  output logic [6:0]                       lastSector
);
  timeunit 1ns;
  timeprecision 1ps;
  import fesr_pkg::*;
  logic [7:0]        mem [logic [ADDR_W-1:0]];
  logic [ADDR_W-1:0] kill [$];
  logic [7:0]        pData = 8'h00;
  logic [7:0]        lastDq = 8'h00;
  logic              armP = 1'b0;
  logic              armE = 1'b0;
  logic              erasing = 1'b0;
  logic              tog = 1'b0;
  int unsigned       remain = 0;
  initial lastSector = 7'h00;
  assign busy = remain != 0;
  // ********************
  // Command writes
  // ********************
  always @(posedge weN) begin
    if (!ceN && resetN && !busy) begin
      if (armP) begin
        mem[addr] = dqIn;
        pData = dqIn;
        erasing = 1'b0;
        remain = PROG_CYC;
        armP = 1'b0;
      end else if (dqIn == 8'ha0) begin
        armP = 1'b1;
      end else if (dqIn == 8'h80) begin
        armE = 1'b1;
      end else if (armE && dqIn == CHIP_ERASE_DATA) begin
        mem.delete();
        erasing = 1'b1;
        remain = ERASE_CYC;
        armE = 1'b0;
      end else if (armE && dqIn == SECTOR_ERASE_DATA) begin
        lastSector = addr[SECTOR_HI:SECTOR_LO];
        kill.delete();
        foreach (mem[a]) begin
          if (a[SECTOR_HI:SECTOR_LO] == lastSector) kill.push_back(a);
        end
        foreach (kill[i]) mem.delete(kill[i]);
        erasing = 1'b1;
        remain = ERASE_CYC;
        armE = 1'b0;
      end
    end
  end
  // ********************
  // Status, reset and read data
  // ********************
  always @(negedge resetN) begin
    remain = 0;
    armP = 1'b0;
    armE = 1'b0;
  end
  always @(posedge clk) begin
    if (busy && !stuck && resetN) remain = remain - 1;
    if (!ceN && !oeN) lastDq <= dqOut;
  end
  always @(negedge oeN) begin
    if (busy) tog = ~tog;
  end
  always @(ceN, oeN, resetN, busy, addr, tog, lastDq) begin
    if (!ceN && !oeN && resetN && busy)
      dqOut = {erasing ? 1'b0 : ~pData[7], tog, pData[5:0]};
    else if (!ceN && !oeN && resetN)
      dqOut = mem.exists(addr) ? mem[addr] : 8'hff;
    else
      dqOut = ~lastDq;
  end
endmodule
`default_nettype wire

/* verification/tb.sv */
// Self-checking testbench of the flash host controller against a flash model.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import fesr_pkg::*;
  localparam int SETUP = 10;
  logic              sys_clk, rst, reqValid, reqReady, doneValid, doneFail, flashDqOe;
  logic              flashCeN, flashOeN, flashWeN, flashResetN, highVoltageIdLevel;
  logic              stuck, fBusy, rsP, oeP, weP, hvP, bsP, rdPend;
  logic [2:0]        reqOp;
  logic [1:0]        reqPollMode;
  logic [ADDR_W-1:0] reqAddr, flashAddr;
  logic [DATA_W-1:0] reqData, doneData, flashDqOut, modelDq;
  logic [6:0]        lastSector;
  wire logic [7:0]   dqBus;
  int                errors, checkCount, cyc, tRF, tRR, tRd, tOeF, tWeF, weLow, minWe;
  int                oeToWe, postReads, opStart;
  int                tHv = -1;
  fesr_host #(.POLL_TIMEOUT(200), .RECOVERY_BUSY(20), .UNPROT_SETUP(SETUP), .PROT_OE(SETUP))
  DUT (.sys_clk(sys_clk), .rst(rst), .reqValid(reqValid), .reqOp(reqOp),
    .reqPollMode(reqPollMode), .reqAddr(reqAddr), .reqData(reqData), .reqReady(reqReady),
    .doneValid(doneValid), .doneFail(doneFail), .doneData(doneData), .flashAddr(flashAddr),
    .flashDqOut(flashDqOut), .flashDqOe(flashDqOe), .flashDqIn(dqBus), .flashCeN(flashCeN),
    .flashOeN(flashOeN), .flashWeN(flashWeN), .flashResetN(flashResetN),
    .highVoltageIdLevel(highVoltageIdLevel));
  fesr_flash_model FLASH (.clk(sys_clk), .stuck(stuck), .addr(flashAddr), .dqIn(dqBus),
    .ceN(flashCeN), .oeN(flashOeN), .weN(flashWeN), .resetN(flashResetN), .dqOut(modelDq),
    .busy(fBusy), .lastSector(lastSector));
  assign dqBus = flashDqOe ? flashDqOut : modelDq;
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // ********************
  // Pin activity monitor
  // ********************
  always @(negedge sys_clk) begin
    cyc++;
    if (!flashResetN && rsP) tRF = cyc;
    if (flashResetN && !rsP) begin
      tRR = cyc;
      rdPend = 1'b1;
    end
    if (!fBusy && bsP) postReads = 0;
    if (!flashOeN && oeP) begin
      tOeF = cyc;
      if (!fBusy) postReads++;
      if (rdPend) tRd = cyc;
      rdPend = 1'b0;
    end
    if (!flashWeN && weP) begin
      weLow = cyc;
      if (tWeF < 0) oeToWe = cyc - tOeF;
      if (tWeF < 0) tWeF = cyc;
    end
    if (flashWeN && !weP && cyc - weLow < minWe) minWe = cyc - weLow;
    if (highVoltageIdLevel && !hvP) tHv = cyc;
    {rsP, oeP, weP, hvP, bsP} = {flashResetN, flashOeN, flashWeN, highVoltageIdLevel, fBusy};
  end
  // ********************
  // Shared tasks
  // ********************
  task automatic wrap_up();
    $display("checks %0d errors %0d", checkCount, errors);
    if (errors == 0 && checkCount > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic ok, input string msg);
    checkCount++;
    if (ok !== 1'b1) begin
      errors++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  task automatic run_op(input logic [2:0] op, input logic [1:0] pm,
                        input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    while (reqReady !== 1'b1 && n < 100) begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 100) begin
      errors++;
      $display("mismatch at %0t: controller never ready", $time);
      wrap_up();
    end
    {reqOp, reqPollMode, reqAddr, reqData} = {op, pm, a, d};
    {tWeF, minWe, postReads, opStart} = {-32'sd1, 32'sd1000, 32'sd0, cyc};
    reqValid = 1'b1;
    @(negedge sys_clk);
    reqValid = 1'b0;
    n = 0;
    while (doneValid !== 1'b1 && n < 6000) begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 6000) begin
      errors++;
      $display("mismatch at %0t: operation never completed", $time);
      wrap_up();
    end
  endtask
  task automatic read_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    run_op(OP_READ, POLL_DATA, a, 8'h00);
    chk(doneData === d, "read data differs");
  endtask
  task automatic prog_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                          input logic [1:0] pm);
    run_op(OP_PROGRAM, pm, a, d);
    chk(doneFail === 1'b0, "program failed");
    read_chk(a, d);
  endtask
  // ********************
  // Scenarios
  // ********************
  task automatic t_erase();
    logic [1:0] pm;
    logic [1:0] cm;
    for (int i = 0; i < 2; i++) begin
      pm = (i == 0) ? POLL_DATA : POLL_TOGGLE;
      cm = (i == 0) ? POLL_TOGGLE : POLL_DATA;
      prog_chk(20'h0a123, 8'h5a, pm);
      prog_chk(20'h12001, 8'ha5, pm);
      run_op(OP_SECTOR_ERASE, pm, 20'h0a000, 8'h00);
      chk(doneFail === 1'b0, "sector erase failed");
      chk(lastSector === 7'h05, "wrong sector erased");
      chk(postReads <= 2, "extra reads after erase");
      read_chk(20'h0a123, 8'hff);
      read_chk(20'h12001, 8'ha5);
      run_op(OP_CHIP_ERASE, cm, 20'h00000, 8'h00);
      chk(doneFail === 1'b0, "chip erase failed");
      chk(postReads <= 2, "extra reads after erase");
      read_chk(20'h12001, 8'hff);
    end
    $display("test erase done");
  endtask
  task automatic t_reset();
    for (int i = 0; i < 2; i++) begin
      stuck = (i == 0);
      run_op(OP_PROGRAM, POLL_DATA, 20'h00010, 8'h3c);
      if (i == 0) chk(doneFail === 1'b1, "no timeout reported");
      run_op(OP_RESET, POLL_DATA, 20'h00000, 8'h00);
      chk(fBusy === 1'b0 && doneFail === 1'b0, "reset did not recover");
      chk(tRR - tRF >= int'(RESET_PULSE_CYC), "reset pulse short");
      stuck = 1'b0;
      read_chk(20'h00010, 8'h3c);
      chk(tRd - tRR >= int'(RESET_HIGH_CYC), "read too soon after reset");
    end
    $display("test reset done");
  endtask
  task automatic t_protect();
    run_op(OP_PROTECT_PULSE, POLL_DATA, 20'h0a000, 8'h00);
    chk(tWeF >= 0 && tOeF >= opStart && oeToWe >= SETUP, "output enable setup short");
    chk(minWe >= int'(PROT_PULSE_CYC), "write pulse short");
    $display("test protect done");
  endtask
  task automatic t_unprotect();
    run_op(OP_UNPROTECT_ENTRY, POLL_DATA, 20'h0a000, 8'h00);
    chk(highVoltageIdLevel === 1'b1 && tHv >= opStart, "no high reset level");
    run_op(OP_PROGRAM, POLL_DATA, 20'h0a010, 8'h11);
    chk(tWeF >= 0 && tWeF - tHv >= SETUP, "strobe before setup time");
    $display("test unprotect done");
  endtask
  initial begin
    {rst, reqValid, stuck, reqOp, reqPollMode, reqAddr, reqData} = '0;
    rst = 1'b1;
    repeat (6) @(negedge sys_clk);
    rst = 1'b0;
    repeat (2) @(negedge sys_clk);
    t_erase();
    t_reset();
    t_protect();
    t_unprotect();
    wrap_up();
  end
endmodule
`default_nettype wire
